// ### hw/analog_scaling_pkg.sv
// Package: constants and carriers for the analog input scaling block
// Functional notes
// - Count of inputs reads two; results read-only
// - Second input optional, valid only when fitted
// - Results in user units: offset and ratio
// - Offset added first, then multiply and divide
// - Default settings give raw converter count
// - Voltage input: 0..1023 digits, 1023 = 3.3 V
// - Current input: full scale 1023 = 20 mA
// - Signed 16-bit multiplier per input, default one
// - Signed 16-bit divisor per input divides product
`default_nettype none
package analog_scaling_pkg;
    // ==========================================================
    // Object dictionary indices and sub-entries
    localparam logic [15:0] IDX_RESULT      = 16'h3320;  // Result values
    localparam logic [15:0] IDX_OFFSET      = 16'h3321;  // Offsets
    localparam logic [15:0] IDX_MULT        = 16'h3322;  // Multipliers
    localparam logic [15:0] IDX_DIV         = 16'h3323;  // Divisors
    localparam logic [7:0]  SUB_COUNT       = 8'h00;     // Number of entries
    localparam logic [7:0]  NUM_INPUTS      = 8'h02;     // Input count
    // ==========================================================
    // Reset values
    localparam logic [31:0] RESULT_RST      = 32'h00000000;
    localparam logic [15:0] OFFSET_RST      = 16'h0000;
    localparam logic [15:0] MULT_RST        = 16'h0001;
    localparam logic [15:0] DIV_RST         = 16'h0001;
    // ==========================================================
    // Converter scale
    localparam logic [9:0]  RAW_FULL_SCALE  = 10'h3FF;   // 1023 digits
    localparam int          FULL_SCALE_MV   = 3300;      // Voltage full scale
    localparam int          FULL_SCALE_UA   = 20000;     // Current full scale
    localparam logic [5:0]  DIV_CYCLES      = 6'h22;     // Cycles from divider load to done
    // ==========================================================
    // Sample from the converter
    typedef struct packed {
        logic       valid;   // One-cycle strobe
        logic       chan;    // Input number 0/1
        logic [9:0] raw;     // Raw digits
    } adc_sample_t;
    // Object access request
    typedef struct packed {
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
        logic [15:0] index;  // Object index
        logic [7:0]  sub;    // Sub-index
        logic [31:0] wdata;  // Write data
    } od_req_t;
endpackage : analog_scaling_pkg
`default_nettype wire

// ### hw/scale_divider.sv
// Signed restoring divider used by the scaling datapath
`timescale 1ns/10ps
`default_nettype none
module scale_divider #(
    parameter int NUM_W = 33,
    parameter int DEN_W = 16
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_b,
    input  wire logic                    clk_en,
    // Request
    input  wire logic                    start,
    input  wire logic signed [NUM_W-1:0] numer,
    input  wire logic signed [DEN_W-1:0] denom,
    // Answer
    output logic                         busy,
    output logic                         done,
    output logic signed [31:0]           quot
);
    // ==========================================================
    // Working state
    logic [NUM_W-1:0]   mag_q;       // Quotient shift register
    logic [NUM_W:0]     rem;         // Partial remainder
    logic [DEN_W-1:0]   mag_d;       // Divisor magnitude
    logic               neg;         // Result sign
    logic [5:0]         count;       // Iterations left
    // Trial subtraction of the next remainder
    wire  [NUM_W:0]     shifted   = {rem[NUM_W-1:0], mag_q[NUM_W-1]};
    wire  [NUM_W:0]     trial     = shifted - {{(NUM_W+1-DEN_W){1'b0}}, mag_d};
    wire                fits      = ~trial[NUM_W];
    wire  [NUM_W-1:0]   abs_n     = numer[NUM_W-1] ? NUM_W'(-numer) : NUM_W'(numer);
    wire  [DEN_W-1:0]   abs_d     = denom[DEN_W-1] ? DEN_W'(-denom) : DEN_W'(denom);
    wire  [NUM_W-1:0]   signed_q  = neg ? NUM_W'(-mag_q) : mag_q;

    // ==========================================================
    // Iterate one quotient bit per cycle; truncates toward zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mag_q <= '0;
            rem   <= '0;
            mag_d <= '0;
            neg   <= 1'b0;
            count <= 6'h00;
            busy  <= 1'b0;
            done  <= 1'b0;
            quot  <= 32'sh00000000;
        end else if (clk_en) begin
            done <= 1'b0;
            if (start && !busy) begin
                // Load magnitudes, keep sign aside
                mag_q <= abs_n;
                rem   <= '0;
                mag_d <= abs_d;
                neg   <= numer[NUM_W-1] ^ denom[DEN_W-1];
                count <= 6'(NUM_W);
                busy  <= 1'b1;
            end else if (busy) begin
                if (count == 6'h00) begin
                    // Result is 32 bits: product of 17x16 bits fits easily
                    quot <= signed_q[31:0];
                    done <= 1'b1;
                    busy <= 1'b0;
                end else begin
                    rem   <= fits ? trial : shifted;
                    mag_q <= {mag_q[NUM_W-2:0], fits};
                    count <= count - 6'h01;
                end
            end
        end
    end
endmodule : scale_divider
`default_nettype wire

// ### hw/analog_input_scaling.sv
// Analog input scaling: offset, multiply, divide, result objects
`timescale 1ns/10ps
`default_nettype none
module analog_input_scaling #(
    parameter bit INPUT2_PRESENT = 1'b1   // Second input fitted
) (
    // Clock, reset, enable
    input  wire logic                             core_clk,
    input  wire logic                             rst_b,
    input  wire logic                             clk_en,
    // Converter samples, same clock domain
    input  wire analog_scaling_pkg::adc_sample_t  adc_sample,
    // Object dictionary access
    input  wire analog_scaling_pkg::od_req_t      od_req,
    output logic                                  od_ack,
    output logic                                  od_err,
    output logic [31:0]                           od_rdata,
    // Status
    output logic                                  div_zero,
    output logic                                  scale_busy
);
    // ==========================================================
    // Per-input settings and results
    logic signed [15:0] offset   [2];  // Added to raw digits
    logic signed [15:0] mult     [2];  // Multiplier
    logic signed [15:0] divisor  [2];  // Divisor
    logic signed [31:0] result   [2];  // Scaled values
    logic        [1:0]  pend;          // Sample waiting per input
    logic        [9:0]  pend_raw [2];  // Raw value waiting
    logic               cur;           // Input in the divider

    // Sequencer states
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_DIV  = 2'b01
    } seq_state_t;
    seq_state_t         state;
    seq_state_t         next_state;

    // ==========================================================
    // Request decode
    wire         sub_ok   = (od_req.sub == 8'h01) || (od_req.sub == 8'h02 && INPUT2_PRESENT);
    wire         sel      = od_req.sub == 8'h02;
    wire         is_res   = od_req.index == analog_scaling_pkg::IDX_RESULT;
    wire         is_cfg   = od_req.index == analog_scaling_pkg::IDX_OFFSET ||
                            od_req.index == analog_scaling_pkg::IDX_MULT   ||
                            od_req.index == analog_scaling_pkg::IDX_DIV;
    wire         is_cnt   = od_req.sub == analog_scaling_pkg::SUB_COUNT;
    wire         known    = (is_res || is_cfg) && (is_cnt || sub_ok);
    // Results and counts refuse writes
    wire         wr_ok    = od_req.wr && is_cfg && sub_ok;
    wire         req      = od_req.wr || od_req.rd;
    wire         bad      = !known || (od_req.wr && !wr_ok);

    // Read mux: count, then per-index entry
    logic [31:0] rd_val;
    always_comb begin
        // Default answer for unknown objects
        rd_val = 32'h00000000;
        if (is_cnt) begin
            rd_val = {24'h000000, analog_scaling_pkg::NUM_INPUTS};
        end else begin
            case (od_req.index)
                analog_scaling_pkg::IDX_RESULT: rd_val = result[sel];
                analog_scaling_pkg::IDX_OFFSET: rd_val = {{16{offset[sel][15]}}, offset[sel]};
                analog_scaling_pkg::IDX_MULT:   rd_val = {{16{mult[sel][15]}}, mult[sel]};
                analog_scaling_pkg::IDX_DIV:    rd_val = {{16{divisor[sel][15]}}, divisor[sel]};
                default:                        rd_val = 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // Datapath: offset first, then product, then divide
    // Input 0 is served first when both wait
    wire                 next_sel = !pend[0];
    wire  [9:0]          raw_now  = pend_raw[next_sel];
    // Raw count is 0..1023 digits, unsigned
    wire  signed [16:0]  sum      = $signed({7'h00, raw_now}) + 17'(offset[next_sel]);
    // Both factors widened first so the product is never cut to the sum's width
    wire  signed [32:0]  product  = 33'(sum) * 33'(mult[next_sel]);
    wire                 zero_div = divisor[next_sel] == 16'sh0000;
    wire                 launch   = (state == S_IDLE) && (pend != 2'b00) && !zero_div;
    wire                 skip     = (state == S_IDLE) && (pend != 2'b00) && zero_div;
    logic                dv_busy;
    logic                dv_done;
    logic signed [31:0]  dv_quot;

    // Sequential divider; one result per 36 cycles
    scale_divider #(
        .NUM_W (33),
        .DEN_W (16)
    ) u_div (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .start    (launch),
        .numer    (product),
        .denom    (divisor[next_sel]),
        .busy     (dv_busy),
        .done     (dv_done),
        .quot     (dv_quot)
    );

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:  if (launch) next_state = S_DIV;
            S_DIV:   if (dv_done) next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    // ==========================================================
    // Settings registers and object answers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 2; i++) begin
                offset[i]  <= analog_scaling_pkg::OFFSET_RST;
                mult[i]    <= analog_scaling_pkg::MULT_RST;
                divisor[i] <= analog_scaling_pkg::DIV_RST;
            end
            od_ack   <= 1'b0;
            od_err   <= 1'b0;
            od_rdata <= 32'h00000000;
        end else if (clk_en) begin
            od_ack <= req;
            od_err <= req && bad;
            if (od_req.rd && !bad) od_rdata <= rd_val;
            if (wr_ok) begin
                // Write the selected setting
                case (od_req.index)
                    analog_scaling_pkg::IDX_OFFSET: offset[sel]  <= od_req.wdata[15:0];
                    analog_scaling_pkg::IDX_MULT:   mult[sel]    <= od_req.wdata[15:0];
                    default:                        divisor[sel] <= od_req.wdata[15:0];
                endcase
            end
        end
    end

    // ==========================================================
    // Sample capture, sequencing and results
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend     <= 2'b00;
            pend_raw <= '{10'h000, 10'h000};
            result   <= '{analog_scaling_pkg::RESULT_RST, analog_scaling_pkg::RESULT_RST};
            cur      <= 1'b0;
            state    <= S_IDLE;
            div_zero <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            // Clear the served slot before catching a new sample: newest wins
            if (launch || skip) pend[next_sel] <= 1'b0;
            if (launch) cur <= next_sel;
            if (adc_sample.valid && (!adc_sample.chan || INPUT2_PRESENT)) begin
                pend[adc_sample.chan]     <= 1'b1;
                pend_raw[adc_sample.chan] <= adc_sample.raw;
            end
            // Zero divisor: drop sample, keep old result
            if (skip) div_zero <= 1'b1;
            else if (launch) div_zero <= 1'b0;
            if (dv_done) result[cur] <= dv_quot;
        end
    end

    assign scale_busy = dv_busy || (state != S_IDLE);

    // ==========================================================
    // Checks
    property p_zero_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (clk_en && skip) |=> (clk_en ? $stable(result[0]) && $stable(result[1]) : 1'b1) && div_zero;
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("zero divisor changed result");

    property p_ro_results;
        @(posedge core_clk) disable iff (!rst_b)
        (clk_en && od_req.wr && is_res) |=> od_err;
    endproperty
    a_ro_results: assert property (p_ro_results) else $error("result write not refused");

    property p_count;
        @(posedge core_clk) disable iff (!rst_b)
        (clk_en && od_req.rd && is_cnt && is_res) |=> od_rdata == 32'h00000002;
    endproperty
    a_count: assert property (p_count) else $error("input count not two");

    property p_opt2;
        @(posedge core_clk) disable iff (!rst_b)
        (!INPUT2_PRESENT && clk_en && req && sel && is_res) |=> od_err;
    endproperty
    a_opt2: assert property (p_opt2) else $error("absent input answered");

    property p_default_raw;
        @(posedge core_clk) disable iff (!rst_b)
        (launch && offset[next_sel] == 16'sh0000 && mult[next_sel] == 16'sh0001 &&
         divisor[next_sel] == 16'sh0001) |-> product == 33'(raw_now);
    endproperty
    a_default_raw: assert property (p_default_raw) else $error("default scaling not raw");

    property p_order;
        @(posedge core_clk) disable iff (!rst_b)
        launch |-> product == ($signed({23'h000000, raw_now}) + 33'(offset[next_sel])) * 33'(mult[next_sel]);
    endproperty
    a_order: assert property (p_order) else $error("offset not applied first");

    property p_finish;
        @(posedge core_clk) disable iff (!rst_b)
        (clk_en && launch) |-> ##[1:80] dv_done;
    endproperty
    a_finish: assert property (p_finish) else $error("division did not finish");

    property p_mult_rst;
        @(posedge core_clk)
        $rose(rst_b) |-> mult[0] == 16'sh0001 && divisor[1] == 16'sh0001;
    endproperty
    a_mult_rst: assert property (p_mult_rst) else $error("multiplier default not one");
endmodule : analog_input_scaling
`default_nettype wire

// ### verif/adc_model.sv
// Converter partner model: one-cycle samples on request from the bench
`timescale 1ns/10ps
`default_nettype none
module adc_model (
    // Clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           rst_b,
    // Conversion request
    input  wire logic                           go,
    input  wire logic                           chan,
    input  wire logic [9:0]                     raw,
    // Sample towards the block
    output var analog_scaling_pkg::adc_sample_t adc_sample
);
    // ==========================================================
    // Sample strobe; data inverted on every idle cycle, so stale values match again every second cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            adc_sample <= '0;
        end else if (go) begin
            adc_sample <= {1'b1, chan, raw};  // Raw held to 10 bits
        end else begin
            adc_sample <= {1'b0, ~adc_sample.chan, ~adc_sample.raw};
        end
    end
endmodule : adc_model
`default_nettype wire

// ### verif/analog_input_scaling_bench.sv
// Self-checking bench for the analog input scaling block
`timescale 1ns/10ps
`default_nettype none
module analog_input_scaling_bench;
    // ==========================================================
    // Stimulus and observed signals
    logic                            core_clk;    // 100 MHz
    logic                            rst_b;       // Async reset
    logic                            clk_en;      // High except in the enable test
    logic                            go;          // Converter request
    logic                            chan;        // Requested input
    logic [9:0]                      raw;         // Requested digits
    analog_scaling_pkg::od_req_t     od_req;      // Object request
    analog_scaling_pkg::adc_sample_t adc_sample;  // From model
    logic                            od_ack;
    logic                            od_err;
    logic [31:0]                     od_rdata;
    logic                            div_zero;
    logic                            scale_busy;
    logic                            err2;        // Refusal, one-input variant
    int                              fail_count;
    int                              checks;
    int                              i;
    int                              s;

    adc_model adc_model_i (.core_clk(core_clk), .rst_b(rst_b), .go(go), .chan(chan), .raw(raw),
        .adc_sample(adc_sample));
    analog_input_scaling analog_input_scaling_i (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
        .adc_sample(adc_sample), .od_req(od_req), .od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata),
        .div_zero(div_zero), .scale_busy(scale_busy));
    // Variant without the second input, sharing all stimulus
    analog_input_scaling #(.INPUT2_PRESENT(1'b0)) analog_input_scaling_i2 (.core_clk(core_clk),
        .rst_b(rst_b), .clk_en(clk_en), .adc_sample(adc_sample), .od_req(od_req), .od_ack(),
        .od_err(err2), .od_rdata(), .div_zero(), .scale_busy());

    // ==========================================================
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ==========================================================
    // Helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One object access; answer checked 1 ns after the taking edge
    task acc(input logic w, input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] d,
             input logic e, input logic [31:0] x);
        @(posedge core_clk);
        od_req <= {w, ~w, idx, sb, d};
        @(posedge core_clk);
        od_req <= '0;
        #1;
        chk({31'h0, od_ack}, 32'h1);
        chk({31'h0, od_err}, {31'h0, e});
        if (!w && !e) chk(od_rdata, x);
    endtask : acc

    task smp(input logic c, input logic [9:0] r);
        @(posedge core_clk);
        go <= 1'b1;
        chan <= c;
        raw <= r;
        @(posedge core_clk);
        go <= 1'b0;
    endtask : smp

    // Wait until the datapath has been idle four cycles, bounded
    task settle;
        int q;
        int n;
        q = 0;
        for (n = 0; n < 300 && q < 4; n++) begin
            @(posedge core_clk);
            #1;
            q = scale_busy ? 0 : q + 1;
        end
        if (q < 4) chk(32'h0, 32'h1);
    endtask : settle

    // Reference: offset first, then multiply, divide toward zero
    function automatic logic [31:0] scl(input int r, input int o, input int m, input int d);
        longint p;
        p = longint'(r + o) * m;
        return 32'(p / d);
    endfunction : scl

    task stop_test;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // ==========================================================
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end

    // ==========================================================
    // Test sequence
    initial begin
        fail_count = 0;
        checks = 0;
        od_req = '0;
        go = 1'b0;
        chan = 1'b0;
        raw = 10'h000;
        clk_en = 1'b1;
        rst_b = 1'b0;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        // Reset values and entry count
        acc(1'b0, analog_scaling_pkg::IDX_RESULT, 8'h00, 32'h0, 1'b0, 32'h00000002);
        for (i = 0; i < 4; i++) begin
            for (s = 1; s < 3; s++) begin
                acc(1'b0, 16'(analog_scaling_pkg::IDX_RESULT + i), 8'(s), 32'h0, 1'b0,
                    (i > 1) ? 32'h00000001 : 32'h00000000);
            end
        end
        chk({31'h0, err2}, 32'h1);
        $display("test reset done");
        // Default settings give raw digits, two samples one idle cycle apart
        smp(1'b0, 10'h3FF);
        smp(1'b1, 10'h155);
        settle();
        acc(1'b0, analog_scaling_pkg::IDX_RESULT, 8'h01, 32'h0, 1'b0, 32'h000003FF);
        acc(1'b0, analog_scaling_pkg::IDX_RESULT, 8'h02, 32'h0, 1'b0, 32'h00000155);
        $display("test default done");
        // Refused accesses leave results intact
        acc(1'b1, analog_scaling_pkg::IDX_RESULT, 8'h01, 32'h5, 1'b1, 32'h0);
        acc(1'b1, analog_scaling_pkg::IDX_OFFSET, 8'h00, 32'h5, 1'b1, 32'h0);
        acc(1'b0, 16'h3324, 8'h01, 32'h0, 1'b1, 32'h0);
        acc(1'b0, analog_scaling_pkg::IDX_DIV, 8'h03, 32'h0, 1'b1, 32'h0);
        acc(1'b0, analog_scaling_pkg::IDX_RESULT, 8'h01, 32'h0, 1'b0, 32'h000003FF);
        $display("test refuse done");
        // Signed offset and ratio on both inputs
        acc(1'b1, analog_scaling_pkg::IDX_OFFSET, 8'h01, 32'h0000FFE8, 1'b0, 32'h0);
        acc(1'b1, analog_scaling_pkg::IDX_MULT, 8'h01, 32'h0000FFFD, 1'b0, 32'h0);
        acc(1'b1, analog_scaling_pkg::IDX_DIV, 8'h01, 32'h00000007, 1'b0, 32'h0);
        acc(1'b1, analog_scaling_pkg::IDX_OFFSET, 8'h02, 32'h00000064, 1'b0, 32'h0);
        acc(1'b1, analog_scaling_pkg::IDX_MULT, 8'h02, 32'h00004E20, 1'b0, 32'h0);
        acc(1'b1, analog_scaling_pkg::IDX_DIV, 8'h02, 32'h000003FF, 1'b0, 32'h0);
        acc(1'b0, analog_scaling_pkg::IDX_OFFSET, 8'h01, 32'h0, 1'b0, 32'hFFFFFFE8);
        smp(1'b0, 10'd1000);
        smp(1'b1, 10'h3FF);
        settle();
        acc(1'b0, analog_scaling_pkg::IDX_RESULT, 8'h01, 32'h0, 1'b0, scl(1000, -24, -3, 7));
        acc(1'b0, analog_scaling_pkg::IDX_RESULT, 8'h02, 32'h0, 1'b0, scl(1023, 100, 20000, 1023));
        $display("test scale done");
        // Zero divisor holds the previous result
        acc(1'b1, analog_scaling_pkg::IDX_DIV, 8'h01, 32'h0, 1'b0, 32'h0);
        smp(1'b0, 10'd5);
        settle();
        chk({31'h0, div_zero}, 32'h1);
        acc(1'b0, analog_scaling_pkg::IDX_RESULT, 8'h01, 32'h0, 1'b0, scl(1000, -24, -3, 7));
        acc(1'b1, analog_scaling_pkg::IDX_DIV, 8'h01, 32'h1, 1'b0, 32'h0);
        smp(1'b0, 10'd30);
        settle();
        chk({31'h0, div_zero}, 32'h0);
        acc(1'b0, analog_scaling_pkg::IDX_RESULT, 8'h01, 32'h0, 1'b0, scl(30, -24, -3, 1));
        $display("test divzero done");
        // Enable low freezes the block: a held read is answered only once enable returns
        @(posedge core_clk);
        clk_en <= 1'b0;
        od_req <= {1'b0, 1'b1, analog_scaling_pkg::IDX_RESULT, 8'h01, 32'h00000000};
        repeat (2) @(posedge core_clk);
        #1;
        chk({31'h0, od_ack}, 32'h0);
        @(posedge core_clk);
        clk_en <= 1'b1;
        @(posedge core_clk);
        od_req <= '0;
        #1;
        chk({31'h0, od_ack}, 32'h1);
        chk(od_rdata, scl(30, -24, -3, 1));
        $display("test enable done");
        stop_test();
    end
endmodule : analog_input_scaling_bench
`default_nettype wire
